// ===== inc/gclk_pkg.sv
package gclk_pkg;

    // Network dimensions.
    localparam int N_INDEX = 8;
    localparam int N_BUF = 16;
    localparam int N_PAD = 16;
    localparam int N_QUAD = 4;
    localparam int MGR_OUTS = 4;
    localparam int MGR_MAX = 4;

    // Buffers at positions p and p + EXCL_SPAN of one edge share routing.
    localparam int EXCL_SPAN = 4;

    // Reset and idle levels.
    localparam logic RST_LEVEL = 1'b0;
    localparam logic SEL_FIRST = 1'b0;
    localparam logic EN_ON = 1'b1;

    // Where a buffer clock input is taken from.
    typedef enum logic [1:0] {
        SRC_PAD = 2'h0,
        SRC_MGR = 2'h1,
        SRC_FABRIC = 2'h2
    } src_kind_t;

    // How a buffer is used.
    typedef enum logic [1:0] {
        MODE_BUF = 2'h0,
        MODE_GATED = 2'h1,
        MODE_MUX = 2'h2
    } buf_mode_t;

    // Pad: idx[1:0] pad of own quadrant. Manager: idx[3:2] unit,
    // idx[1:0] output. Fabric: idx selects one of sixteen lines.
    typedef struct packed {
        src_kind_t kind;
        logic [3:0] idx;
    } src_cfg_t;

    // The two source lines shared by a primary and its partner.
    typedef struct packed {
        src_cfg_t first;
        src_cfg_t second;
    } pair_cfg_t;

    // Per quadrant, which index uses primary and which secondary.
    typedef struct packed {
        logic [N_INDEX-1:0] use_p;
        logic [N_INDEX-1:0] use_s;
    } quad_cfg_t;

    typedef struct packed {
        logic [N_QUAD-1:0] quad;
        logic [1:0] edge_excl;
        logic [N_INDEX-1:0] sec_blocked;
    } conflict_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'h1,
        ST_HOLD = 2'h2
    } sel_state_t;

endpackage : gclk_pkg

// ===== rtl/clock_select_cell.sv
module clock_select_cell
    import gclk_pkg::*;
(
    // Clock and reset
    input logic core_clk,
    input logic rst_n,
    // Sampled clock levels
    input logic first_clock_input,
    input logic second_clock_input,
    // Controls from general interconnect
    input logic sel,
    input logic en,
    // Buffered clock
    output logic out_ff
);

    sel_state_t st_ff;
    logic cur_ff;
    logic gate_ff;
    logic first_prev_ff;
    logic second_prev_ff;
    logic src;
    logic oth_fell;

    // Level now driving the output, and a fall of the other input.
    assign src = cur_ff ? second_clock_input : first_clock_input;
    assign oth_fell = cur_ff ? (first_prev_ff & ~first_clock_input)
                             : (second_prev_ff & ~second_clock_input);

    // Previous input levels for fall detection.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_prev_ff <= RST_LEVEL;
            second_prev_ff <= RST_LEVEL;
        end else begin
            first_prev_ff <= first_clock_input;
            second_prev_ff <= second_clock_input;
        end
    end

    // A select change is taken only while the current clock is low, so
    // a high phase is never cut; the output then waits for a fall.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_RUN;
            cur_ff <= SEL_FIRST;
        end else begin
            unique case (st_ff)
                ST_RUN: begin
                    if (sel != cur_ff && !src) begin
                        st_ff <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (oth_fell) begin
                        st_ff <= ST_RUN;
                        cur_ff <= ~cur_ff;
                    end
                end
                default: st_ff <= ST_RUN;
            endcase
        end
    end

    // Enable is sampled in the low phase, so a pulse passes whole.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_ff <= RST_LEVEL;
        end else if (!src) begin
            gate_ff <= en;
        end
    end

    // Output is held low while a switch is pending.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= RST_LEVEL;
        end else begin
            out_ff <= (st_ff == ST_RUN) & src & gate_ff;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_low_sel_first: assert property (
        st_ff == ST_RUN && !cur_ff && gate_ff
        |=> out_ff == $past(first_clock_input))
        else $error("low select did not pass the first input");
    a_hold_low: assert property (st_ff == ST_HOLD |=> !out_ff)
        else $error("output not low during switch");
    a_gate_stop: assert property (
        st_ff == ST_RUN && !gate_ff && !src && !en |=> !out_ff [*2])
        else $error("disabled buffer passed a pulse");
    c_switch: cover property (st_ff == ST_HOLD ##1 st_ff == ST_RUN);
    c_gate_off: cover property (gate_ff ##1 !gate_ff);

endmodule : clock_select_cell

// ===== rtl/global_clock_network_routing.sv
// Notes on behaviour
// - Each buffer acts as glitch-free two-input multiplexer.
// - Select and enable come from general interconnect.
// - Inputs come from pads, managers or interconnect.
// - Pads reach only own-quadrant buffer clock inputs.
// - Manager outputs reach buffers on same edge.
// - Buffer outputs reach quadrants and non-clock logic.
// - Eight primary, eight secondary, identical hardware.
// - Indices 0-7, pair members on the same edge.
// - One same-index buffer per quadrant at most.
// - Paired buffers share their two inputs crosswise.
// - Edge pads feed managers; managers drive edge buffers.
// - A manager drives one buffer per exclusive pair.
// - Eight trees per quadrant, any output enters.
// - Eight buffers top centre, eight bottom centre.
// - Every quadrant sink can use any net.
// - Primary in all quadrants blocks its secondary.
// - Select low picks first input, high second.
module global_clock_network_routing
    import gclk_pkg::*;
#(
    parameter int MGRS = MGR_MAX
)(
    // Clock and reset
    input logic core_clk,
    input logic rst_n,
    // Dedicated clock pads, asynchronous
    input logic [N_PAD-1:0] pad_clk,
    // Manager outputs, edge-major, four per unit, asynchronous
    input logic [2*MGRS*MGR_OUTS-1:0] mgr_out,
    // General interconnect, one line per buffer
    input logic [N_BUF-1:0] fab_clk,
    input logic [N_BUF-1:0] fab_sel,
    input logic [N_BUF-1:0] fab_en,
    // Static routing configuration
    input pair_cfg_t [N_INDEX-1:0] pair_cfg,
    input buf_mode_t [N_BUF-1:0] buf_mode,
    input quad_cfg_t [N_QUAD-1:0] quad_cfg,
    input logic [2*MGRS-1:0][2:0] mgr_pad_sel,
    input logic [N_QUAD-1:0][2:0] tap_sel,
    // Manager inputs
    output logic [2*MGRS-1:0] manager_clock_input,
    // Buffer outputs, primaries 0-7 then secondaries 0-7
    output logic [N_BUF-1:0] gbuf_out,
    // Quadrant nets and taps
    output logic [N_QUAD-1:0][N_INDEX-1:0] quad_net,
    output logic [N_QUAD-1:0] quad_tap,
    // Configuration checker
    output conflict_t conflict,
    output logic conflict_any
);

    localparam int MGR_BITS = 2 * MGRS * MGR_OUTS;

    logic [N_PAD-1:0] pad_m_ff;
    logic [N_PAD-1:0] pad_s_ff;
    logic [MGR_BITS-1:0] mgr_m_ff;
    logic [MGR_BITS-1:0] mgr_s_ff;
    src_cfg_t [N_BUF-1:0] cfg_first;
    src_cfg_t [N_BUF-1:0] cfg_second;
    logic [N_BUF-1:0] buf_bot;
    logic [N_BUF-1:0] in_first;
    logic [N_BUF-1:0] in_second;
    logic [N_BUF-1:0] sel_in;
    logic [N_BUF-1:0] en_in;
    logic [1:0][MGR_MAX-1:0][N_INDEX-1:0] drv;
    logic [1:0] excl;
    logic [N_QUAD-1:0] quad_both;
    logic [N_INDEX-1:0] p_all;
    logic [N_INDEX-1:0] s_any;
    logic [N_INDEX-1:0] sec_blocked;

    if (MGRS < 1 || MGRS > MGR_MAX) begin : g_bad_mgrs
        $error("MGRS must lie between one and MGR_MAX");
    end

    // Pads and manager outputs are foreign clocks; two stages each.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_m_ff <= '0;
            pad_s_ff <= '0;
            mgr_m_ff <= '0;
            mgr_s_ff <= '0;
        end else begin
            pad_m_ff <= pad_clk;
            pad_s_ff <= pad_m_ff;
            mgr_m_ff <= mgr_out;
            mgr_s_ff <= mgr_m_ff;
        end
    end

    // Resolves one buffer clock input. Pads are limited to the buffer's
    // own quadrant and managers to its own edge, as dedicated routing
    // allows; anything else would need interconnect as a fabric source.
    function automatic logic pick(
        input src_cfg_t c,
        input logic bot,
        input logic east,
        input logic [N_PAD-1:0] pads,
        input logic [MGR_BITS-1:0] mgrs,
        input logic [N_BUF-1:0] fab
    );
        int mi;
        mi = (int'(bot) * MGRS + int'(c.idx[3:2])) * MGR_OUTS
             + int'(c.idx[1:0]);
        pick = 1'b0;
        case (c.kind)
            SRC_PAD: begin
                pick = pads[{bot, east, c.idx[1:0]}];
            end
            SRC_MGR: begin
                if (int'(c.idx[3:2]) < MGRS) begin
                    pick = mgrs[mi];
                end
            end
            SRC_FABRIC: begin
                pick = fab[c.idx];
            end
            default: begin
                pick = 1'b0;
            end
        endcase
    endfunction : pick

    // Buffer b: primary index b for b < 8, else secondary index b - 8.
    // Primary i shares its two lines with secondary i ^ 1, crosswise.
    for (genvar b = 0; b < N_BUF; b++) begin : g_buf
        localparam int IDX = b % N_INDEX;
        localparam bit SEC = (b >= N_INDEX);
        localparam int KEY = SEC ? (IDX ^ 1) : IDX;
        // Odd primaries and even secondaries sit on the top edge.
        localparam bit BOT = SEC ? (IDX % 2 == 1) : (IDX % 2 == 0);
        localparam bit EAST = (IDX / EXCL_SPAN) == 1;

        assign buf_bot[b] = BOT;
        assign cfg_first[b] = SEC ? pair_cfg[KEY].second
                                  : pair_cfg[KEY].first;
        assign cfg_second[b] = SEC ? pair_cfg[KEY].first
                                   : pair_cfg[KEY].second;
        assign in_first[b] = pick(cfg_first[b], BOT, EAST,
                                  pad_s_ff, mgr_s_ff, fab_clk);
        assign in_second[b] = pick(cfg_second[b], BOT, EAST,
                                   pad_s_ff, mgr_s_ff, fab_clk);

        // Plain buffers hold the first input and stay enabled.
        assign sel_in[b] = (buf_mode[b] == MODE_MUX) ? fab_sel[b]
                                                     : SEL_FIRST;
        assign en_in[b] = (buf_mode[b] == MODE_GATED) ? fab_en[b]
                                                      : EN_ON;

        // The same cell serves primary and secondary alike.
        clock_select_cell u_cell (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .first_clock_input(in_first[b]),
            .second_clock_input(in_second[b]),
            .sel(sel_in[b]),
            .en(en_in[b]),
            .out_ff(gbuf_out[b])
        );
    end

    // Every buffer output is offered at each quadrant boundary and is
    // also a port, so non-clock logic can read it.
    for (genvar q = 0; q < N_QUAD; q++) begin : g_quad
        quadrant_clock_tree #(
            .NETS(N_INDEX)
        ) u_tree (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .prim(gbuf_out[N_INDEX-1:0]),
            .sec(gbuf_out[N_BUF-1:N_INDEX]),
            .use_p(quad_cfg[q].use_p),
            .use_s(quad_cfg[q].use_s),
            .tap_sel(tap_sel[q]),
            .net_ff(quad_net[q]),
            .tap_ff(quad_tap[q])
        );
    end

    // Each manager takes any of the eight pads of its own edge.
    // A registered copy keeps the manager input free of decode glitches.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            manager_clock_input <= '0;
        end else begin
            for (int m = 0; m < 2 * MGRS; m++) begin
                manager_clock_input[m] <=
                    pad_s_ff[{m >= MGRS, mgr_pad_sel[m]}];
            end
        end
    end

    // Which manager drives which edge position. Only the inputs that a
    // mode really uses count, so a spare shared line raises no alarm.
    always_comb begin
        drv = '0;
        for (int b = 0; b < N_BUF; b++) begin
            if (cfg_first[b].kind == SRC_MGR
                && int'(cfg_first[b].idx[3:2]) < MGRS) begin
                drv[buf_bot[b]][cfg_first[b].idx[3:2]][b % N_INDEX] = 1'b1;
            end
            if (buf_mode[b] == MODE_MUX && cfg_second[b].kind == SRC_MGR
                && int'(cfg_second[b].idx[3:2]) < MGRS) begin
                drv[buf_bot[b]][cfg_second[b].idx[3:2]][b % N_INDEX] =
                    1'b1;
            end
        end
    end

    // Positions p and p + 4 of one edge form an exclusive pair.
    // The pair shares dedicated routing, so one manager feeds one member.
    always_comb begin
        excl = '0;
        for (int e = 0; e < 2; e++) begin
            for (int m = 0; m < MGR_MAX; m++) begin
                excl[e] = excl[e]
                    | (|(drv[e][m][N_INDEX-1:EXCL_SPAN]
                         & drv[e][m][EXCL_SPAN-1:0]));
            end
        end
    end

    // Same-index clashes per quadrant, and secondaries shut out by a
    // primary that already reaches all four quadrants.
    always_comb begin
        quad_both = '0;
        p_all = '1;
        s_any = '0;
        for (int q = 0; q < N_QUAD; q++) begin
            quad_both[q] = |(quad_cfg[q].use_p & quad_cfg[q].use_s);
            p_all = p_all & quad_cfg[q].use_p;
            s_any = s_any | quad_cfg[q].use_s;
        end
        sec_blocked = p_all & s_any;
    end

    // Checker flags are levels that follow the configuration.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            conflict <= '0;
            conflict_any <= RST_LEVEL;
        end else begin
            conflict.quad <= quad_both;
            conflict.edge_excl <= excl;
            conflict.sec_blocked <= sec_blocked;
            conflict_any <= |{quad_both, excl, sec_blocked};
        end
    end

    // All checks run on the core clock and rest while reset is held.
    // Checker flags are registered, so they lag their cause by one edge.
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_pair_share: assert property (
        in_second[1] == in_first[N_INDEX] && in_first[1] == in_second[N_INDEX])
        else $error("1P and 0S do not share inputs crosswise");
    a_pair_bottom: assert property (
        in_second[0] == in_first[N_INDEX+1]
        && in_first[0] == in_second[N_INDEX+1])
        else $error("0P and 1S do not share inputs crosswise");
    a_quad_flag: assert property (|quad_both |=> conflict_any)
        else $error("same-index clash not flagged");
    a_excl_flag: assert property (
        excl != '0 |=> conflict.edge_excl == $past(excl) && conflict_any)
        else $error("exclusive pair clash not flagged");
    a_sec_blocked: assert property (
        sec_blocked != '0 |=> conflict.sec_blocked == $past(sec_blocked))
        else $error("blocked secondary not flagged");
    a_flag_clear: assert property (
        quad_both == '0 && excl == '0 && sec_blocked == '0
        |=> !conflict_any)
        else $error("conflict flag without cause");

    // Fixed placement: even primaries and odd secondaries sit at the
    // bottom, so each index has one unit on either edge.
    a_edge_place: assert property (buf_bot == 16'hAA55)
        else $error("buffer placed on the wrong edge");

    // Source routing spot checks on three buffers of the top edge. A pad
    // must come from the own quadrant, a manager from the own edge.
    a_pad_quad: assert property (
        cfg_first[1].kind == SRC_PAD
        |-> in_first[1] == pad_s_ff[{2'h0, cfg_first[1].idx[1:0]}])
        else $error("pad reached a buffer of another quadrant");
    a_mgr_edge: assert property (
        cfg_first[5].kind == SRC_MGR && int'(cfg_first[5].idx[3:2]) < MGRS
        |-> in_first[5] == mgr_s_ff[cfg_first[5].idx])
        else $error("manager reached a buffer of the other edge");
    a_fab_src: assert property (
        cfg_first[3].kind == SRC_FABRIC
        |-> in_first[3] == fab_clk[cfg_first[3].idx])
        else $error("interconnect line did not reach the buffer");

    // Manager inputs lag their pad by the synchroniser and one register.
    a_mgr_pad: assert property (
        manager_clock_input[0] == $past(pad_s_ff[{1'b0, mgr_pad_sel[0]}]))
        else $error("top manager did not take its selected pad");

    c_conflict: cover property (|quad_both ##1 conflict_any);
    c_sec_blocked: cover property (|sec_blocked ##1 conflict_any);

endmodule : global_clock_network_routing

// ===== rtl/quadrant_clock_tree.sv
module quadrant_clock_tree
    import gclk_pkg::*;
#(
    parameter int NETS = N_INDEX
)(
    // Clock and reset
    input logic core_clk,
    input logic rst_n,
    // Buffer outputs by index
    input logic [NETS-1:0] prim,
    input logic [NETS-1:0] sec,
    // Quadrant entry selection
    input logic [NETS-1:0] use_p,
    input logic [NETS-1:0] use_s,
    input logic [$clog2(NETS)-1:0] tap_sel,
    // Quadrant nets and a sink tap
    output logic [NETS-1:0] net_ff,
    output logic tap_ff
);

    if (NETS < 2) begin : g_bad_nets
        $error("NETS must be at least two");
    end

    // One tree per index: primary wins a clash so a net never carries
    // two clocks at once; unused trees stay low to save power.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            net_ff <= '0;
        end else begin
            net_ff <= (prim & use_p) | (sec & use_s & ~use_p);
        end
    end

    // Any sink of the quadrant may take any of its nets.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_ff <= RST_LEVEL;
        end else begin
            tap_ff <= net_ff[tap_sel];
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_one_per_index: assert property (
        (use_p & use_s) != '0
        |=> ((net_ff ^ $past(prim)) & $past(use_p & use_s)) == '0)
        else $error("both same-index buffers reached one net");
    a_idle_low: assert property (
        (use_p | use_s) == '0 ##1 (use_p | use_s) == '0 |=> net_ff == '0)
        else $error("unused tree carried a clock");
    c_clash: cover property (|(use_p & use_s));

endmodule : quadrant_clock_tree

// ===== sim/global_clock_network_routing_tb_top.sv
module global_clock_network_routing_tb_top
    import gclk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MG = 4;

    logic core_clk;
    logic rst_n;
    logic [N_PAD-1:0] pad_clk;
    logic [2*MG*MGR_OUTS-1:0] mgr_out;
    logic [N_BUF-1:0] fab_clk;
    logic [N_BUF-1:0] fab_sel;
    logic [N_BUF-1:0] fab_en;
    pair_cfg_t [N_INDEX-1:0] pair_cfg;
    buf_mode_t [N_BUF-1:0] buf_mode;
    quad_cfg_t [N_QUAD-1:0] quad_cfg;
    logic [2*MG-1:0][2:0] mgr_pad_sel;
    logic [N_QUAD-1:0][2:0] tap_sel;
    logic [2*MG-1:0] manager_clock_input;
    logic [N_BUF-1:0] gbuf_out;
    logic [N_QUAD-1:0][N_INDEX-1:0] quad_net;
    logic [N_QUAD-1:0] quad_tap;
    conflict_t conflict;
    logic conflict_any;
    logic [N_QUAD-1:0][7:0] sink_edges;
    int n_errors = 0;
    int checked = 0;

    global_clock_network_routing #(.MGRS(MG)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .pad_clk(pad_clk),
        .mgr_out(mgr_out), .fab_clk(fab_clk), .fab_sel(fab_sel),
        .fab_en(fab_en), .pair_cfg(pair_cfg), .buf_mode(buf_mode),
        .quad_cfg(quad_cfg), .mgr_pad_sel(mgr_pad_sel),
        .tap_sel(tap_sel), .manager_clock_input(manager_clock_input),
        .gbuf_out(gbuf_out), .quad_net(quad_net), .quad_tap(quad_tap),
        .conflict(conflict), .conflict_any(conflict_any)
    );

    quad_sink_model sink (
        .core_clk(core_clk), .rst_n(rst_n), .quad_tap(quad_tap),
        .edges_ff(sink_edges)
    );

    // Free-running core clock of 20 ns.
    always #10 core_clk = ~core_clk;

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkv

    // Outputs are read just after an edge, before its updates land.
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // Bounded wait on one buffer output; running out ends the run.
    task automatic wait_gbuf(input int id, input logic lvl);
        int i;
        for (i = 0; i < 12; i++) begin
            @(posedge core_clk);
            if (gbuf_out[id] === lvl) break;
        end
        if (i == 12) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, gbuf_out[id], lvl);
            end_sim();
        end
    endtask : wait_gbuf

    function automatic src_cfg_t src(input src_kind_t k, input logic [3:0] i);
        src_cfg_t s;
        s.kind = k;
        s.idx = i;
        return s;
    endfunction : src

    task automatic test_reset();
        chkv(gbuf_out, 16'h0000);
        chkv(16'(conflict_any), 16'h0000);
        chkv(16'(|quad_net), 16'h0000);
        chkv(16'(|manager_clock_input), 16'h0000);
        rst_n <= 1'b1;
        tick(3);
        $display("test reset done");
    endtask : test_reset

    // Pad of the north-west quadrant into primary 1, entering that quadrant.
    task automatic test_pad_path();
        pair_cfg[1].first <= src(SRC_PAD, 4'h2);
        quad_cfg[0].use_p[1] <= 1'b1;
        tap_sel[0] <= 3'h1;
        tick(4);
        for (int k = 0; k < 3; k++) begin
            pad_clk[2] <= 1'b1;
            wait_gbuf(1, 1'b1);
            tick(1);
            chkv(16'(quad_net[0][1]), 16'h0001);
            chkv(16'(quad_net[1][1]), 16'h0000);
            pad_clk[2] <= 1'b0;
            wait_gbuf(1, 1'b0);
        end
        tick(6);
        chkv(16'(sink_edges[0]), 16'h0003);
        chkv(16'(sink_edges[1]), 16'h0000);
        $display("test pad path done");
    endtask : test_pad_path

    // Primary 3 and secondary 2 share fabric lines 4 and 5 crosswise.
    task automatic test_mux_switch();
        pair_cfg[3] <= {src(SRC_FABRIC, 4'h4), src(SRC_FABRIC, 4'h5)};
        buf_mode[3] <= MODE_MUX;
        buf_mode[10] <= MODE_MUX;
        tick(4);
        fab_clk[5] <= 1'b1;
        wait_gbuf(10, 1'b1);
        chkv(16'(gbuf_out[3]), 16'h0000);
        fab_clk[4] <= 1'b1;
        wait_gbuf(3, 1'b1);
        fab_clk[4] <= 1'b0;
        wait_gbuf(3, 1'b0);
        fab_sel[3] <= 1'b1;
        tick(2);
        fab_clk[4] <= 1'b1;
        tick(4);
        chkv(16'(gbuf_out[3]), 16'h0000);
        fab_clk[4] <= 1'b0;
        fab_clk[5] <= 1'b0;
        tick(4);
        fab_clk[5] <= 1'b1;
        wait_gbuf(3, 1'b1);
        $display("test mux switch done");
    endtask : test_mux_switch

    // Gated use of primary 5; a high phase in progress is not cut.
    task automatic test_gate();
        pair_cfg[5].first <= src(SRC_FABRIC, 4'h6);
        buf_mode[5] <= MODE_GATED;
        tick(3);
        fab_clk[6] <= 1'b1;
        tick(4);
        chkv(16'(gbuf_out[5]), 16'h0000);
        fab_clk[6] <= 1'b0;
        fab_en[5] <= 1'b1;
        tick(3);
        fab_clk[6] <= 1'b1;
        wait_gbuf(5, 1'b1);
        fab_en[5] <= 1'b0;
        tick(3);
        chkv(16'(gbuf_out[5]), 16'h0001);
        fab_clk[6] <= 1'b0;
        wait_gbuf(5, 1'b0);
        fab_clk[6] <= 1'b1;
        tick(4);
        chkv(16'(gbuf_out[5]), 16'h0000);
        fab_clk[6] <= 1'b0;
        $display("test gate done");
    endtask : test_gate

    // Same-index use in one quadrant, then primary 4 in all quadrants.
    task automatic test_quad_conflict();
        quad_cfg[2].use_p[3] <= 1'b1;
        quad_cfg[2].use_s[3] <= 1'b1;
        tick(3);
        chkv(16'(conflict.quad), 16'h0004);
        chkv(16'(quad_net[2][3]), 16'h0001);
        chkv(16'(conflict_any), 16'h0001);
        quad_cfg[2].use_s[3] <= 1'b0;
        for (int q = 1; q < N_QUAD; q++) quad_cfg[q].use_p[4] <= 1'b1;
        quad_cfg[0].use_s[4] <= 1'b1;
        tick(3);
        chkv(16'(conflict.sec_blocked), 16'h0000);
        chkv(16'(conflict_any), 16'h0000);
        quad_cfg[0].use_p[4] <= 1'b1;
        tick(3);
        chkv(16'(conflict.sec_blocked), 16'h0010);
        chkv(16'(conflict.quad), 16'h0001);
        quad_cfg[0].use_s[4] <= 1'b0;
        tick(3);
        chkv(16'(conflict_any), 16'h0000);
        $display("test quad conflict done");
    endtask : test_quad_conflict

    // Manager exclusive pairs on both edges, manager path, manager inputs.
    task automatic test_manager();
        buf_mode[5] <= MODE_BUF;
        pair_cfg[1].first <= src(SRC_MGR, 4'h0);
        pair_cfg[5].first <= src(SRC_MGR, 4'h1);
        pair_cfg[0].first <= src(SRC_MGR, 4'h4);
        pair_cfg[4].first <= src(SRC_MGR, 4'h6);
        tick(3);
        chkv(16'(conflict.edge_excl), 16'h0003);
        pair_cfg[5].first <= src(SRC_MGR, 4'h5);
        pair_cfg[4].first <= src(SRC_MGR, 4'h8);
        tick(3);
        chkv(16'(conflict.edge_excl), 16'h0000);
        mgr_out[5] <= 1'b1;
        wait_gbuf(5, 1'b1);
        mgr_out[5] <= 1'b0;
        wait_gbuf(5, 1'b0);
        mgr_pad_sel[0] <= 3'h6;
        mgr_pad_sel[MG] <= 3'h1;
        pad_clk[6] <= 1'b1;
        pad_clk[9] <= 1'b1;
        tick(5);
        chkv(16'(manager_clock_input), 16'h0011);
        $display("test manager done");
    endtask : test_manager

    // Everything at rest from time zero, reset held for two cycles.
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        pad_clk = '0;
        mgr_out = '0;
        fab_clk = '0;
        fab_sel = '0;
        fab_en = '0;
        pair_cfg = '0;
        buf_mode = '0;
        quad_cfg = '0;
        mgr_pad_sel = '0;
        tap_sel = '0;
        tick(2);
        test_reset();
        test_pad_path();
        test_mux_switch();
        test_gate();
        test_quad_conflict();
        test_manager();
        end_sim();
    end
endmodule : global_clock_network_routing_tb_top

// ===== sim/quad_sink_model.sv
module quad_sink_model
    import gclk_pkg::*;
(
    // Clock and reset
    input logic core_clk,
    input logic rst_n,
    // Quadrant taps seen by fabric registers
    input logic [N_QUAD-1:0] quad_tap,
    // Rising edges counted per quadrant
    output logic [N_QUAD-1:0][7:0] edges_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [N_QUAD-1:0] last_ff;

    // Clocks are levels here, so a sink edge is a sampled rise of its tap.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_ff <= '0;
            edges_ff <= '0;
        end else begin
            last_ff <= quad_tap;
            for (int q = 0; q < N_QUAD; q++) begin
                if (quad_tap[q] && !last_ff[q]) begin
                    edges_ff[q] <= edges_ff[q] + 8'h01;
                end
            end
        end
    end
endmodule : quad_sink_model
